//--- verilog/sbrg_pkg.sv
// Shared constants for the serial baud-rate generator block
package sbrg_pkg;
    localparam int unsigned DIV_W       = 13;
    localparam int unsigned OVS_RATE    = 16;
    localparam int unsigned ADDR_W      = 8;
    localparam int unsigned DATA_W      = 32;

    localparam logic [7:0]  ADDR_HIGH   = 8'h00;
    localparam logic [7:0]  ADDR_LOW    = 8'h04;
    localparam logic [7:0]  ADDR_CTRL   = 8'h08;
    localparam logic [7:0]  ADDR_STAT   = 8'h0c;
    localparam logic [7:0]  ADDR_ICLR   = 8'h10;
    localparam logic [7:0]  ADDR_IEN    = 8'h14;

    localparam int unsigned HI_BRK_IE   = 7;
    localparam int unsigned HI_RXE_IE   = 6;
    localparam int unsigned HI_DIV_MSB  = 4;
    localparam int unsigned CTL_RX_ON   = 0;
    localparam int unsigned CTL_TX_ON   = 1;
    localparam int unsigned CTL_PSEL    = 2;
    localparam int unsigned EV_BRK      = 0;
    localparam int unsigned EV_RXE      = 1;
    localparam int unsigned ST_ACTIVE   = 2;
    localparam int unsigned ST_DIV_LSB  = 16;

    localparam logic [7:0]  HIGH_RST    = 8'h00;
    localparam logic [7:0]  LOW_RST     = 8'h04;
    localparam logic [7:0]  CTRL_RST    = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;
endpackage

//--- verilog/sbrg_baud_div.sv
// Modulo divider producing the oversample tick and the bit tick
`timescale 1ns/1ns
module sbrg_baud_div
    import sbrg_pkg::*;
#(
    parameter int unsigned W   = DIV_W,
    parameter int unsigned OVS = OVS_RATE
) (
    input  wire logic         clk_i,
    input  wire logic         rst_n_i,
    input  wire logic         run_i,
    input  wire logic         load_i,
    input  wire logic [W-1:0] divisor_i,
    output logic              tick16_o,
    output logic              baud_tick_o
);
    localparam int unsigned OW = $clog2(OVS);

    typedef struct packed {
        logic [W-1:0]  cnt;
        logic [OW-1:0] ovs;
        logic          tick;
        logic          baud;
    } sbrg_div_t;

    sbrg_div_t s_r;
    sbrg_div_t s_nxt;

    always_comb begin
        s_nxt      = s_r;
        s_nxt.tick = 1'b0;
        s_nxt.baud = 1'b0;
        // Stopped or reloading: counters cleared, no ticks
        if (!run_i || load_i) begin
            s_nxt.cnt = '0;
            s_nxt.ovs = '0;
        end else if (s_r.cnt == divisor_i - W'(1)) begin
            s_nxt.cnt  = '0;
            s_nxt.tick = 1'b1;
            s_nxt.ovs  = s_r.ovs + OW'(1);
            s_nxt.baud = (s_r.ovs == OW'(OVS - 1));
        end else begin
            s_nxt.cnt = s_r.cnt + W'(1);
        end
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r <= '0;
        end else begin
            s_r <= s_nxt;
        end
    end

    assign tick16_o    = s_r.tick;
    assign baud_tick_o = s_r.baud;

    // Checking helpers: cycles since last tick, valid while running steadily
    logic [W:0] gap_r;
    logic       gap_ok_r;
    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            gap_r    <= '0;
            gap_ok_r <= 1'b0;
        end else begin
            gap_r    <= tick16_o ? (W+1)'(1) : gap_r + (W+1)'(1);
            gap_ok_r <= (run_i && !load_i) ? (tick16_o | gap_ok_r) : 1'b0;
        end
    end

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_TICK_PERIOD: assert property (tick16_o && gap_ok_r && run_i && !load_i |->
        gap_r == {1'b0, divisor_i})
        else $error("oversample tick spacing differs from divisor");
    AST_BAUD_WITH_TICK: assert property (baud_tick_o |-> tick16_o)
        else $error("bit tick without oversample tick");
    AST_NO_TICK_STOPPED: assert property (!$past(run_i) |-> !tick16_o)
        else $error("tick while generator stopped");
    COV_BAUD: cover property (baud_tick_o);
endmodule

//--- verilog/sbrg_top.sv
// Baud-rate generator with buffered divisor, event flags and pin routing
`timescale 1ns/1ns
module sbrg_top
    import sbrg_pkg::*;
(
    input  wire logic              clk_i,
    input  wire logic              rst_n_i,
    input  wire logic [ADDR_W-1:0] avs_address_i,
    input  wire logic              avs_read_i,
    input  wire logic              avs_write_i,
    input  wire logic [DATA_W-1:0] avs_writedata_i,
    input  wire logic [3:0]        avs_byteenable_i,
    output logic      [DATA_W-1:0] avs_readdata_o,
    output logic                   avs_waitrequest_o,
    input  wire logic              break_detect_ev_i,
    input  wire logic              rx_edge_ev_i,
    input  wire logic              link2_tx_i,
    output logic                   link2_rx_o,
    input  wire logic              port_f_bit_one_i,
    input  wire logic              port_e_bit_seven_i,
    output logic                   port_f_bit_zero_o,
    output logic                   port_f_bit_zero_oe_o,
    output logic                   port_e_bit_six_o,
    output logic                   port_e_bit_six_oe_o,
    output logic                   tick16_o,
    output logic                   baud_tick_o,
    output logic                   gen_active_o,
    output logic                   irq_o
);
    typedef struct packed {
        logic              wait_req;
        logic [DATA_W-1:0] rdata;
        logic [4:0]        hi_buf;
        logic [4:0]        hi_work;
        logic              brk_ie;
        logic              rxe_ie;
        logic [7:0]        low;
        logic              rx_on;
        logic              tx_on;
        logic              pos_sel;
        logic              armed;
        logic              brk_flag;
        logic              rxe_flag;
        logic              irq;
        logic              active;
        logic              div_load;
        logic              f0;
        logic              f0_oe;
        logic              e6;
        logic              e6_oe;
        logic              rx_out;
        logic [1:0]        sync_f1;
        logic [1:0]        sync_e7;
    } sbrg_state_t;

    sbrg_state_t s_r;
    sbrg_state_t s_nxt;

    logic [DIV_W-1:0] divisor;
    logic             req;
    logic             wr_go;
    logic             rd_go;
    logic [7:0]       wbyte;

    assign divisor = {s_r.hi_work, s_r.low};
    assign req     = avs_read_i | avs_write_i;
    // Write lands only on the edge where waitrequest is seen low
    assign wr_go   = avs_write_i && !s_r.wait_req && avs_byteenable_i[0];
    assign rd_go   = avs_read_i && s_r.wait_req;
    assign wbyte   = avs_writedata_i[7:0];

    always_comb begin
        s_nxt          = s_r;
        s_nxt.div_load = 1'b0;
        // One wait cycle per access, then release for a cycle
        s_nxt.wait_req = !(req && s_r.wait_req);

        if (rd_go) begin
            unique case (avs_address_i)
                ADDR_HIGH: begin
                    s_nxt.rdata = {24'h00_0000, s_r.brk_ie, s_r.rxe_ie, 1'b0,
                                   s_r.hi_buf};
                end
                ADDR_LOW: begin
                    s_nxt.rdata = {24'h00_0000, s_r.low};
                end
                ADDR_CTRL: begin
                    s_nxt.rdata = UNMAPPED_RD;
                    s_nxt.rdata[CTL_RX_ON] = s_r.rx_on;
                    s_nxt.rdata[CTL_TX_ON] = s_r.tx_on;
                    s_nxt.rdata[CTL_PSEL]  = s_r.pos_sel;
                end
                ADDR_STAT: begin
                    s_nxt.rdata = UNMAPPED_RD;
                    s_nxt.rdata[EV_BRK]    = s_r.brk_flag;
                    s_nxt.rdata[EV_RXE]    = s_r.rxe_flag;
                    s_nxt.rdata[ST_ACTIVE] = s_r.active;
                    s_nxt.rdata[ST_DIV_LSB +: DIV_W] = divisor;
                end
                ADDR_IEN: begin
                    s_nxt.rdata = UNMAPPED_RD;
                    s_nxt.rdata[EV_BRK] = s_r.brk_ie;
                    s_nxt.rdata[EV_RXE] = s_r.rxe_ie;
                end
                default: begin
                    s_nxt.rdata = UNMAPPED_RD;
                end
            endcase
        end

        if (wr_go) begin
            unique case (avs_address_i)
                ADDR_HIGH: begin
                    // Divisor bits only buffered, working upper bits wait for the low write; the interrupt enables take effect at once
                    s_nxt.hi_buf = wbyte[HI_DIV_MSB:0];
                    s_nxt.brk_ie = wbyte[HI_BRK_IE];
                    s_nxt.rxe_ie = wbyte[HI_RXE_IE];
                end
                ADDR_LOW: begin
                    s_nxt.low      = wbyte;
                    s_nxt.hi_work  = s_r.hi_buf;
                    s_nxt.div_load = 1'b1;
                end
                ADDR_CTRL: begin
                    s_nxt.rx_on   = wbyte[CTL_RX_ON];
                    s_nxt.tx_on   = wbyte[CTL_TX_ON];
                    s_nxt.pos_sel = wbyte[CTL_PSEL];
                    if (wbyte[CTL_RX_ON] || wbyte[CTL_TX_ON]) begin
                        s_nxt.armed = 1'b1;
                    end
                end
                ADDR_ICLR: begin
                    if (wbyte[EV_BRK]) begin
                        s_nxt.brk_flag = 1'b0;
                    end
                    if (wbyte[EV_RXE]) begin
                        s_nxt.rxe_flag = 1'b0;
                    end
                end
                ADDR_IEN: begin
                    s_nxt.brk_ie = wbyte[EV_BRK];
                    s_nxt.rxe_ie = wbyte[EV_RXE];
                end
                default: begin
                end
            endcase
        end

        // Set after clear so a same-cycle event is never lost
        if (break_detect_ev_i) begin
            s_nxt.brk_flag = 1'b1;
        end
        if (rx_edge_ev_i) begin
            s_nxt.rxe_flag = 1'b1;
        end
        s_nxt.irq = (s_nxt.brk_flag & s_nxt.brk_ie)
                  | (s_nxt.rxe_flag & s_nxt.rxe_ie);

        // Zero divisor or not yet armed holds the divider stopped with its counters cleared
        s_nxt.active = s_r.armed && (divisor != '0);

        // Pin routing; the unused transmit pad is released
        s_nxt.sync_f1 = {s_r.sync_f1[0], port_f_bit_one_i};
        s_nxt.sync_e7 = {s_r.sync_e7[0], port_e_bit_seven_i};
        s_nxt.f0      = s_r.pos_sel ? 1'b1 : link2_tx_i;
        s_nxt.f0_oe   = !s_r.pos_sel;
        s_nxt.e6      = s_r.pos_sel ? link2_tx_i : 1'b1;
        s_nxt.e6_oe   = s_r.pos_sel;
        s_nxt.rx_out  = s_r.pos_sel ? s_r.sync_e7[1] : s_r.sync_f1[1];
    end

    always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            s_r          <= '0;
            s_r.wait_req <= 1'b1;
            s_r.brk_ie   <= HIGH_RST[HI_BRK_IE];
            s_r.rxe_ie   <= HIGH_RST[HI_RXE_IE];
            s_r.hi_buf   <= HIGH_RST[HI_DIV_MSB:0];
            s_r.hi_work  <= HIGH_RST[HI_DIV_MSB:0];
            s_r.low      <= LOW_RST;
            s_r.pos_sel  <= CTRL_RST[CTL_PSEL];
            s_r.f0       <= 1'b1;
            s_r.f0_oe    <= 1'b1;
            s_r.e6       <= 1'b1;
            s_r.rx_out   <= 1'b1;
            s_r.sync_f1  <= 2'h3;
            s_r.sync_e7  <= 2'h3;
        end else begin
            s_r <= s_nxt;
        end
    end

    sbrg_baud_div #(
        .W   (DIV_W),
        .OVS (OVS_RATE)
    ) u_div (
        .clk_i       (clk_i),
        .rst_n_i     (rst_n_i),
        .run_i       (s_r.active),
        .load_i      (s_r.div_load),
        .divisor_i   (divisor),
        .tick16_o    (tick16_o),
        .baud_tick_o (baud_tick_o)
    );

    assign avs_readdata_o       = s_r.rdata;
    assign avs_waitrequest_o    = s_r.wait_req;
    assign link2_rx_o           = s_r.rx_out;
    assign port_f_bit_zero_o    = s_r.f0;
    assign port_f_bit_zero_oe_o = s_r.f0_oe;
    assign port_e_bit_six_o     = s_r.e6;
    assign port_e_bit_six_oe_o  = s_r.e6_oe;
    assign gen_active_o         = s_r.active;
    assign irq_o                = s_r.irq;

    logic hi_wr;
    logic lo_wr;
    assign hi_wr = wr_go && (avs_address_i == ADDR_HIGH);
    assign lo_wr = wr_go && (avs_address_i == ADDR_LOW);

    logic clr_wr;
    logic ctl_wr;
    logic ien_wr;
    assign clr_wr = wr_go && (avs_address_i == ADDR_ICLR);
    assign ctl_wr = wr_go && (avs_address_i == ADDR_CTRL);
    assign ien_wr = wr_go && (avs_address_i == ADDR_IEN);

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rst_n_i);

    AST_HIGH_HELD: assert property (hi_wr |=> s_r.hi_work == $past(s_r.hi_work))
        else $error("high write changed working divisor bits");
    AST_LOW_COMMIT: assert property (lo_wr |=>
        s_r.hi_work == $past(s_r.hi_buf) && s_r.low == $past(wbyte))
        else $error("low write did not commit both halves");
    AST_FIELD_MAP: assert property (rd_go && avs_address_i == ADDR_STAT |=>
        avs_readdata_o[ST_DIV_LSB +: DIV_W] == {$past(s_r.hi_work), $past(s_r.low)}
        && !avs_waitrequest_o)
        else $error("status divisor field misplaced");
    AST_ZERO_STOPS: assert property ((divisor == '0)[*3] |-> !tick16_o && !gen_active_o)
        else $error("generator running with zero divisor");
    AST_IDLE_UNARMED: assert property (!s_r.armed |-> !gen_active_o && !tick16_o)
        else $error("generator active before rx or tx enabled");
    AST_BRK_IRQ: assert property (s_r.brk_flag && s_r.brk_ie |-> irq_o)
        else $error("enabled break flag without interrupt");
    AST_RXE_IRQ: assert property (s_r.rxe_flag && s_r.rxe_ie |-> irq_o)
        else $error("enabled edge flag without interrupt");
    AST_IRQ_QUIET: assert property (!(s_r.brk_flag && s_r.brk_ie) &&
        !(s_r.rxe_flag && s_r.rxe_ie) |-> !irq_o)
        else $error("interrupt without enabled flag");
    AST_POS_ROUTE: assert property (s_r.pos_sel |=> port_e_bit_six_oe_o &&
        !port_f_bit_zero_oe_o && port_e_bit_six_o == $past(link2_tx_i))
        else $error("link 2 transmit not routed to port E");
    AST_RELOAD: assert property (lo_wr |=> s_r.div_load ##1 !tick16_o)
        else $error("divider not reloaded on divisor change");
    AST_SET_WINS: assert property (break_detect_ev_i |=> s_r.brk_flag)
        else $error("break event lost");

    // Bus handshake and register fields
    AST_WAIT_ONE: assert property (req && avs_waitrequest_o |=>
        !avs_waitrequest_o)
        else $error("waitrequest held past one cycle");
    AST_WAIT_BACK: assert property (!avs_waitrequest_o |=>
        avs_waitrequest_o)
        else $error("waitrequest low for two cycles");
    AST_LOW_MASKED: assert property (avs_write_i && !avs_waitrequest_o &&
        !avs_byteenable_i[0] |=> $stable(s_r.low))
        else $error("masked write changed low register");
    AST_HI_BUF: assert property (hi_wr |=>
        {s_r.brk_ie, s_r.rxe_ie, 1'b0, s_r.hi_buf} == ($past(wbyte) & 8'hdf))
        else $error("high write fields misplaced");
    AST_HIGH_READ: assert property (rd_go && avs_address_i == ADDR_HIGH |=>
        avs_readdata_o[7:0] == {$past(s_r.brk_ie), $past(s_r.rxe_ie), 1'b0, $past(s_r.hi_buf)})
        else $error("high read fields misplaced");
    AST_LOW_READ: assert property (rd_go && avs_address_i == ADDR_LOW |=>
        avs_readdata_o == {24'h00_0000, $past(s_r.low)})
        else $error("low read misplaced");

    // Generator enable
    AST_ACTIVE_ON: assert property (s_r.armed && divisor != '0 |=> gen_active_o)
        else $error("armed generator with divisor not running");
    AST_ACTIVE_OFF: assert property (divisor == '0 |=> !gen_active_o)
        else $error("generator left running at zero divisor");
    AST_ARM: assert property (ctl_wr && (wbyte[CTL_RX_ON] || wbyte[CTL_TX_ON]) |=>
        s_r.armed)
        else $error("enable write did not arm generator");
    AST_ARM_KEPT: assert property (s_r.armed |=> s_r.armed)
        else $error("generator disarmed without reset");
    AST_LOAD_CAUSE: assert property (s_r.div_load |-> $past(lo_wr))
        else $error("divider reload without low write");

    // Sticky flags; a clear never beats a same-cycle event
    AST_RXE_SET: assert property (rx_edge_ev_i |=> s_r.rxe_flag)
        else $error("edge event lost");
    AST_BRK_CLR: assert property (clr_wr && wbyte[EV_BRK] && !break_detect_ev_i |=>
        !s_r.brk_flag)
        else $error("break flag not cleared");
    AST_RXE_CLR: assert property (clr_wr && wbyte[EV_RXE] && !rx_edge_ev_i |=>
        !s_r.rxe_flag)
        else $error("edge flag not cleared");
    AST_BRK_HOLD: assert property (s_r.brk_flag && !(clr_wr && wbyte[EV_BRK]) |=>
        s_r.brk_flag)
        else $error("break flag dropped without clear");
    AST_RXE_HOLD: assert property (s_r.rxe_flag && !(clr_wr && wbyte[EV_RXE]) |=>
        s_r.rxe_flag)
        else $error("edge flag dropped without clear");
    AST_STAT_FLAGS: assert property (rd_go && avs_address_i == ADDR_STAT |=>
        avs_readdata_o[2:0] == {$past(s_r.active), $past(s_r.rxe_flag), $past(s_r.brk_flag)})
        else $error("status flags misplaced");
    AST_IEN_ALIAS: assert property (ien_wr |=>
        {6'h00, s_r.rxe_ie, s_r.brk_ie} == ($past(wbyte) & 8'h03))
        else $error("enable register not aliased");

    // Pin routing
    AST_CTRL_BITS: assert property (ctl_wr |=>
        {5'h00, s_r.pos_sel, s_r.tx_on, s_r.rx_on} == ($past(wbyte) & 8'h07))
        else $error("control bits misplaced");
    AST_CTRL_READ: assert property (rd_go && avs_address_i == ADDR_CTRL |=>
        avs_readdata_o == {29'h0, $past(s_r.pos_sel), $past(s_r.tx_on), $past(s_r.rx_on)})
        else $error("control read misplaced");
    AST_F_ROUTE: assert property (!s_r.pos_sel |=> port_f_bit_zero_oe_o &&
        !port_e_bit_six_oe_o && port_e_bit_six_o && port_f_bit_zero_o == $past(link2_tx_i))
        else $error("link 2 transmit not routed to port F");
    AST_RX_ROUTE_E: assert property (s_r.pos_sel |=>
        link2_rx_o == $past(s_r.sync_e7[1]))
        else $error("link 2 receive not taken from port E");
    AST_RX_ROUTE_F: assert property (!s_r.pos_sel |=>
        link2_rx_o == $past(s_r.sync_f1[1]))
        else $error("link 2 receive not taken from port F");

    COV_LOW_WRITE: cover property (hi_wr ##[1:4] lo_wr);
    COV_IRQ_RISE: cover property (!irq_o ##1 irq_o);
    COV_TICK: cover property (gen_active_o ##[1:40] tick16_o);
    COV_POS_SWAP: cover property (!s_r.pos_sel ##1 s_r.pos_sel);
endmodule

//--- verif/sbrg_remote_xcvr.sv
// Far-end serial transceiver model wired to one of the two pad pairs
`timescale 1ns/1ns
module sbrg_remote_xcvr (
    input  wire logic f_tx_i,
    input  wire logic f_oe_i,
    input  wire logic e_tx_i,
    input  wire logic e_oe_i,
    input  wire logic on_e_i,
    input  wire logic send_i,
    output logic      f_rx_o,
    output logic      e_rx_o,
    output logic      seen_o
);
    // Released pads float to the pull-up level
    assign seen_o = on_e_i ? (e_oe_i ? e_tx_i : 1'b1) : (f_oe_i ? f_tx_i : 1'b1);
    // Unwired receive pad idles high, so a wrong route shows
    assign f_rx_o = on_e_i ? 1'b1 : send_i;
    assign e_rx_o = on_e_i ? send_i : 1'b1;
endmodule

//--- verif/sci_baud_rate_generator_test.sv
// Self-checking bench for the baud-rate generator block
`timescale 1ns/1ns
module sci_baud_rate_generator_test
    import sbrg_pkg::*;
;
    logic              clk_i = 1'b0;
    logic              rst_n_i = 1'b0;
    logic [ADDR_W-1:0] avs_address_i = '0;
    logic              avs_read_i = 1'b0;
    logic              avs_write_i = 1'b0;
    logic [DATA_W-1:0] avs_writedata_i = '0;
    logic [3:0]        avs_byteenable_i = 4'hf;
    logic [DATA_W-1:0] avs_readdata_o;
    logic              avs_waitrequest_o;
    logic              brk_ev = 1'b0;
    logic              rxe_ev = 1'b0;
    logic              link2_tx_i = 1'b1;
    logic              on_e = 1'b0;
    logic              send = 1'b1;
    logic              f1, e7, f0, f0_oe, e6, e6_oe, seen, link2_rx_o;
    logic              tick16_o, baud_tick_o, gen_active_o, irq_o;
    int                bad_count = 0;
    int                tests_run = 0;
    logic [31:0]       q;
    logic [31:0]       g;

    always #20 clk_i = ~clk_i;

    sbrg_top sbrg_top_inst (
        .clk_i(clk_i), .rst_n_i(rst_n_i), .avs_address_i(avs_address_i),
        .avs_read_i(avs_read_i), .avs_write_i(avs_write_i),
        .avs_writedata_i(avs_writedata_i), .avs_byteenable_i(avs_byteenable_i),
        .avs_readdata_o(avs_readdata_o), .avs_waitrequest_o(avs_waitrequest_o),
        .break_detect_ev_i(brk_ev), .rx_edge_ev_i(rxe_ev), .link2_tx_i(link2_tx_i),
        .link2_rx_o(link2_rx_o), .port_f_bit_one_i(f1), .port_e_bit_seven_i(e7),
        .port_f_bit_zero_o(f0), .port_f_bit_zero_oe_o(f0_oe), .port_e_bit_six_o(e6),
        .port_e_bit_six_oe_o(e6_oe), .tick16_o(tick16_o), .baud_tick_o(baud_tick_o),
        .gen_active_o(gen_active_o), .irq_o(irq_o));

    sbrg_remote_xcvr sbrg_remote_xcvr_inst (
        .f_tx_i(f0), .f_oe_i(f0_oe), .e_tx_i(e6), .e_oe_i(e6_oe), .on_e_i(on_e),
        .send_i(send), .f_rx_o(f1), .e_rx_o(e7), .seen_o(seen));

    task automatic stop_test;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask

    task automatic check(input string what, input logic [31:0] sv, input logic [31:0] ev);
        tests_run++;
        if (sv !== ev) begin
            bad_count++;
            $display("unexpected %s: expected %h seen %h", what, ev, sv);
        end
    endtask

    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n;
        @(posedge clk_i);
        avs_address_i   <= a;
        avs_writedata_i <= d;
        avs_write_i     <= wr;
        avs_read_i      <= ~wr;
        n = 0;
        @(posedge clk_i);
        while (avs_waitrequest_o !== 1'b0) begin
            n++;
            @(posedge clk_i);
        end
        q = avs_readdata_o;
        avs_write_i <= 1'b0;
        avs_read_i  <= 1'b0;
        check("wait cycles", n, 32'h1);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        bus(1'b1, a, d);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] ev, input string what);
        bus(1'b0, a, 32'h0);
        check(what, q, ev);
    endtask

    function automatic logic [31:0] st(input logic [12:0] d, input logic [2:0] f);
        return {3'h0, d, 13'h0, f};
    endfunction

    // Cycles between two ticks; zero when none comes within the limit
    task automatic gap(input logic baud);
        int n;
        n = 0;
        g = 32'h0;
        @(negedge clk_i);
        while ((baud ? baud_tick_o : tick16_o) !== 1'b1 && n < 9000) begin
            @(negedge clk_i);
            n++;
        end
        while (n < 9000) begin
            @(negedge clk_i);
            g++;
            if ((baud ? baud_tick_o : tick16_o) === 1'b1 || g > 9000) n = 9000;
        end
    endtask

    task automatic pulse(input logic rx_edge);
        @(posedge clk_i);
        brk_ev <= ~rx_edge;
        rxe_ev <= rx_edge;
        @(posedge clk_i);
        brk_ev <= 1'b0;
        rxe_ev <= 1'b0;
    endtask

    task automatic irq_is(input logic ev);
        @(negedge clk_i);
        check("irq", {31'h0, irq_o}, {31'h0, ev});
    endtask

    task automatic t_reset;
        rd(ADDR_HIGH, {24'h0, HIGH_RST}, "high reset");
        rd(ADDR_LOW, {24'h0, LOW_RST}, "low reset");
        rd(8'h20, UNMAPPED_RD, "unmapped read");
        avs_byteenable_i <= 4'h0;
        wr(ADDR_LOW, 32'h55);
        avs_byteenable_i <= 4'hf;
        wr(8'h20, 32'hff);
        rd(ADDR_LOW, {24'h0, LOW_RST}, "masked write");
        gap(1'b0);
        check("idle tick gap", g, 32'h0);
        check("idle active", {31'h0, gen_active_o}, 32'h0);
    endtask

    task automatic t_div;
        wr(ADDR_CTRL, 32'h2);
        gap(1'b0);
        check("tick gap", g, 32'h4);
        gap(1'b1);
        check("baud gap", g, 32'h40);
        wr(ADDR_HIGH, 32'h1);
        rd(ADDR_STAT, st(13'h4, 3'h4), "held divisor");
        wr(ADDR_LOW, 32'h0);
        rd(ADDR_STAT, st(13'h100, 3'h4), "divisor");
        gap(1'b0);
        check("tick gap", g, 32'h100);
        wr(ADDR_HIGH, 32'h1f);
        wr(ADDR_LOW, 32'hff);
        rd(ADDR_STAT, st(13'h1fff, 3'h4), "max divisor");
        gap(1'b0);
        check("max tick gap", g, 32'h1fff);
        wr(ADDR_HIGH, 32'h0);
        wr(ADDR_LOW, 32'h0);
        gap(1'b0);
        check("stopped tick gap", g, 32'h0);
        rd(ADDR_STAT, st(13'h0, 3'h0), "stopped");
        wr(ADDR_LOW, 32'h1);
        gap(1'b0);
        check("min tick gap", g, 32'h1);
    endtask

    task automatic t_irq;
        pulse(1'b0);
        rd(ADDR_STAT, st(13'h1, 3'h5), "break flag");
        irq_is(1'b0);
        wr(ADDR_HIGH, 32'h80);
        irq_is(1'b1);
        wr(ADDR_ICLR, 32'h1);
        irq_is(1'b0);
        wr(ADDR_IEN, 32'h2);
        rd(ADDR_IEN, 32'h2, "enable alias");
        rd(ADDR_HIGH, 32'h40, "high enables");
        pulse(1'b1);
        irq_is(1'b1);
        wr(ADDR_HIGH, 32'h0);
        irq_is(1'b0);
        wr(ADDR_ICLR, 32'h2);
        rd(ADDR_STAT, st(13'h1, 3'h4), "flags cleared");
    endtask

    // Both lines held low, so only the pad pair in use can pass them
    task automatic route(input logic e);
        on_e <= e;
        repeat (5) @(posedge clk_i);
        @(negedge clk_i);
        check("rx route", {31'h0, link2_rx_o}, 32'h0);
        check("tx route", {31'h0, seen}, 32'h0);
        check("idle pad oe", {31'h0, e ? f0_oe : e6_oe}, 32'h0);
    endtask

    task automatic t_port;
        send <= 1'b0;
        link2_tx_i <= 1'b0;
        route(1'b0);
        wr(ADDR_CTRL, 32'h6);
        route(1'b1);
    endtask

    // Mid-run reset, then arm through the receive enable alone
    task automatic t_rearm;
        @(posedge clk_i);
        rst_n_i <= 1'b0;
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        rd(ADDR_CTRL, {24'h0, CTRL_RST}, "ctrl reset");
        check("rearm idle", {31'h0, gen_active_o}, 32'h0);
        wr(ADDR_CTRL, 32'h1);
        rd(ADDR_CTRL, 32'h1, "ctrl rx on");
        gap(1'b0);
        check("rx armed tick gap", g, {24'h0, LOW_RST});
    endtask

    initial begin
        repeat (3) @(posedge clk_i);
        rst_n_i <= 1'b1;
        t_reset();
        t_div();
        t_irq();
        t_port();
        t_rearm();
        stop_test();
    end

    initial begin
        repeat (60000) @(posedge clk_i);
        bad_count++;
        stop_test();
    end
endmodule
